// ### core/psb_stage.sv
`timescale 1ns/100ps
// protection stage: pick-up, blocking, operate and release timing
module psb_stage
  import psb_pkg::*;
#(
  parameter int TICK_CYC = PSB_TICK_CYC  // program cycle length in clocks
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  input  wire logic        BLOCK_IN,
  input  wire logic [15:0] MEAS_MAG,
  input  wire logic [3:0]  FAULT_TYPE,
  output logic             START,
  output logic             BLOCKED,
  output logic             TRIP,
  output logic             HMI_EVT,
  output logic             IRQ
);
  // indication decode, used for pins and status read
  function automatic psb_ind_t ind_of(psb_state_t s);
    psb_ind_t r;
    r.start   = (s == ST_TIMING) || (s == ST_TRIPPED);
    r.blocked = (s == ST_BLOCKED);
    r.trip    = (s == ST_TRIPPED);
    return r;
  endfunction

  psb_ctrl_t   ctrl_q;       // delay type and curve selects
  logic [23:0] def_q;        // definite delay in ticks
  logic [11:0] tdial_q;      // time dial in hundredths
  logic [23:0] reld_q;       // release delay in ticks
  logic [15:0] pick_q;       // pickup_setting
  logic [15:0] custa_q;      // custom curve constant
  logic [PSB_EV_W-1:0] evt_q;   // sticky events
  logic [PSB_EV_W-1:0] mask_q;  // interrupt mask
  logic [PSB_EV_W-1:0] evt_set; // events raised this cycle
  logic [15:0] rec_mag_q;    // magnitude at blocking
  logic [3:0]  rec_ft_q;     // fault type at blocking
  logic [31:0] rec_time_q;   // tick stamp at blocking
  logic [31:0] stamp_q;      // free tick counter
  logic [31:0] rdata_q;      // read data, one cycle late

  logic [16:0] div_q;        // program cycle divider
  logic        tick;         // one-cycle program cycle pulse
  logic        blk;          // synchronised blocking input
  logic        blk_smp_q;    // blocking as sampled at tick
  logic        pickup_q;     // hysteresis pickup state
  logic        pick_now;     // pickup seen at this tick
  logic [31:0] drop_lvl;     // 97 percent of setting
  psb_state_t  st_q;         // sequencer state
  psb_state_t  st_d;
  logic [23:0] elapsed_q;    // operate ticks counted
  logic [23:0] elapsed_d;
  logic [23:0] rel_q;        // release ticks counted
  logic [23:0] rel_d;
  logic [23:0] inv_ticks;    // curve delay
  logic [23:0] tgt;          // selected operate delay
  logic        blk_evt;      // blocking occurrence this tick
  psb_ind_t    ind;

  // pin crosses two flops before anything looks at it
  psb_sync u_sync (
    .CLK (CLK),
    .RST (RST),
    .d   (BLOCK_IN),
    .q   (blk)
  );

  psb_inv_delay u_inv (
    .CLK     (CLK),
    .RST     (RST),
    .ctrl    (ctrl_q),
    .mag     (MEAS_MAG),
    .pick    (pick_q),
    .tdial   (tdial_q),
    .cust_a  (custa_q),
    .ticks_q (inv_ticks)
  );

  // program cycle divider, the only slow rate
  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      div_q <= 17'h0_0000;
    else if (tick)
      div_q <= 17'h0_0000;
    else
      div_q <= div_q + 17'h0_0001;
  end
  assign tick = (div_q == 17'(TICK_CYC - 1));

  // tick stamp for event records
  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      stamp_q <= 32'h0000_0000;
    else if (tick)
      stamp_q <= stamp_q + 32'h0000_0001;
  end

  // blocking latched first thing in each program cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      blk_smp_q <= 1'b0;
    else if (tick)
      blk_smp_q <= blk;
  end

  // hysteresis: rise at setting, fall under 97 percent of it
  assign drop_lvl = (32'(pick_q) * 32'(PSB_HYST_PCT)) / 32'(PSB_PCT_FULL);
  always_comb begin
    if (!pickup_q)
      pick_now = (MEAS_MAG >= pick_q);
    else
      pick_now = (32'(MEAS_MAG) >= drop_lvl);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      pickup_q <= 1'b0;
    else if (tick)
      pickup_q <= pick_now;
  end

  // floor of the definite delay; zero floor falls out of the max
  always_comb begin
    if (ctrl_q.inv_mode)
      tgt = (inv_ticks > def_q) ? inv_ticks : def_q;
    else
      tgt = def_q;
  end

  // sequencer, evaluated only on the tick, blocking decided first
  always_comb begin
    st_d      = st_q;
    elapsed_d = elapsed_q;
    rel_d     = rel_q;
    blk_evt   = 1'b0;
    if (tick) begin
      case (st_q)
        ST_IDLE: begin
          elapsed_d = 24'h00_0000;
          rel_d     = 24'h00_0000;
          if (pick_now && blk) begin
            st_d    = ST_BLOCKED;
            blk_evt = 1'b1;
          end else if (pick_now) begin
            // zero delay trips alongside start
            st_d = (tgt == 24'h00_0000) ? ST_TRIPPED : ST_TIMING;
          end
        end
        ST_TIMING: begin
          if (blk || !pick_now) begin
            // blocking behaves as a pickup drop
            blk_evt   = blk;
            rel_d     = 24'h00_0000;
            st_d      = (reld_q == 24'h00_0000) ? ST_IDLE
                                                 : ST_RELEASE;
          end else if (elapsed_q + 24'h00_0001 >= tgt) begin
            st_d = ST_TRIPPED;
          end else begin
            elapsed_d = elapsed_q + 24'h00_0001;
          end
        end
        ST_RELEASE: begin
          // operate count held; resumes if pickup returns in time
          if (pick_now && !blk) begin
            st_d = ST_TIMING;
          end else if (rel_q + 24'h00_0001 >= reld_q) begin
            st_d      = ST_IDLE;
            elapsed_d = 24'h00_0000;
          end else begin
            rel_d = rel_q + 24'h00_0001;
          end
        end
        ST_TRIPPED: begin
          if (blk || !pick_now) begin
            blk_evt = blk;
            st_d    = ST_IDLE;
          end
        end
        ST_BLOCKED: begin
          // held until pickup drops; no timing while here
          if (!pick_now)
            st_d = ST_IDLE;
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q      <= ST_IDLE;
      elapsed_q <= 24'h00_0000;
      rel_q     <= 24'h00_0000;
    end else begin
      st_q      <= st_d;
      elapsed_q <= elapsed_d;
      rel_q     <= rel_d;
    end
  end

  assign ind     = ind_of(st_q);
  assign START   = ind.start;
  assign BLOCKED = ind.blocked;
  assign TRIP    = ind.trip;

  // display pulse and record of each blocking
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      HMI_EVT    <= 1'b0;
      rec_mag_q  <= 16'h0000;
      rec_ft_q   <= 4'h0;
      rec_time_q <= 32'h0000_0000;
    end else begin
      HMI_EVT <= blk_evt;
      if (blk_evt) begin
        rec_mag_q  <= MEAS_MAG;
        rec_ft_q   <= FAULT_TYPE;
        rec_time_q <= stamp_q;
      end
    end
  end

  // settings written over the plain port
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_q  <= '0;
      def_q   <= PSB_DEF_RST;
      tdial_q <= PSB_TDIAL_RST;
      reld_q  <= 24'h00_0000;
      pick_q  <= PSB_PICK_RST;
      custa_q <= PSB_CUSTA_RST;
      mask_q  <= '0;
    end else if (REG_WR) begin
      case (REG_ADDR)
        PSB_A_CTRL:  ctrl_q  <= REG_WDATA[$bits(psb_ctrl_t)-1:0];
        PSB_A_DEF:   def_q   <= REG_WDATA[23:0];
        PSB_A_TDIAL: tdial_q <= REG_WDATA[11:0];
        PSB_A_RELD:  reld_q  <= REG_WDATA[23:0];
        PSB_A_PICK:  pick_q  <= REG_WDATA[15:0];
        PSB_A_CUSTA: custa_q <= REG_WDATA[15:0];
        PSB_A_MASK:  mask_q  <= REG_WDATA[PSB_EV_W-1:0];
        default:     ;
      endcase
    end
  end

  // sticky events; a set in the clearing read cycle survives
  always_comb begin
    evt_set               = '0;
    evt_set[PSB_EV_BLOCK] = blk_evt;
    evt_set[PSB_EV_START] = tick && (st_q == ST_IDLE) && (st_d != ST_IDLE)
                            && (st_d != ST_BLOCKED);
    evt_set[PSB_EV_TRIP]  = (st_q != ST_TRIPPED) && (st_d == ST_TRIPPED);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      evt_q <= '0;
    else if (REG_RD && (REG_ADDR == PSB_A_EVT))
      evt_q <= evt_set;
    else
      evt_q <= evt_q | evt_set;
  end

  assign IRQ = |(evt_q & mask_q);

  // read mux, data valid the cycle after the strobe
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= 32'h0000_0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        PSB_A_CTRL:  rdata_q <= 32'(ctrl_q);
        PSB_A_DEF:   rdata_q <= 32'(def_q);
        PSB_A_TDIAL: rdata_q <= 32'(tdial_q);
        PSB_A_RELD:  rdata_q <= 32'(reld_q);
        PSB_A_PICK:  rdata_q <= 32'(pick_q);
        PSB_A_CUSTA: rdata_q <= 32'(custa_q);
        PSB_A_STAT:  rdata_q <= 32'({blk_smp_q, pickup_q, ind});
        PSB_A_EVT:   rdata_q <= 32'(evt_q);
        PSB_A_MASK:  rdata_q <= 32'(mask_q);
        PSB_A_RMAG:  rdata_q <= 32'(rec_mag_q);
        PSB_A_RINFO: rdata_q <= 32'(rec_ft_q);
        PSB_A_RTIME: rdata_q <= rec_time_q;
        default:     rdata_q <= 32'h0000_0000; // unmapped reads zero
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign REG_RDATA = rdata_q;

  // checks, sampled on the system clock
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_blocked_no_trip: assert property (
    BLOCKED |-> !TRIP && !START)
    else $error("blocked stage shows start or trip");

  a_idle_block_path: assert property (
    tick && st_q == ST_IDLE && pick_now && blk |=> BLOCKED && HMI_EVT)
    else $error("pickup under blocking not flagged blocked");

  a_start_path: assert property (
    tick && st_q == ST_IDLE && pick_now && !blk && tgt != 24'h00_0000
    |=> START && !TRIP)
    else $error("unblocked pickup did not start timing");

  a_zero_delay_trip: assert property (
    tick && st_q == ST_IDLE && pick_now && !blk && tgt == 24'h00_0000
    |=> START && TRIP)
    else $error("zero delay did not trip with start");

  a_block_clears: assert property (
    tick && blk && START |=> !START && HMI_EVT)
    else $error("late blocking left start raised");

  a_drop_release: assert property (
    tick && st_q == ST_TIMING && !pick_now |=> !START && !TRIP)
    else $error("drop before trip kept start or tripped");

  a_trip_at_count: assert property (
    $rose(TRIP) && $past(st_q) == ST_TIMING
    |-> $past(elapsed_q) + 24'h00_0001 >= $past(tgt))
    else $error("trip before delay elapsed");

  a_inv_floor: assert property (
    tick && st_q == ST_TIMING && ctrl_q.inv_mode && pick_now && !blk
    && elapsed_q + 24'h00_0001 < def_q |=> !TRIP)
    else $error("inverse trip beat the definite floor");

  a_tick_only: assert property (
    !tick |=> $stable(st_q) && $stable(blk_smp_q))
    else $error("sequencer moved between program cycles");

  a_hyst_hold: assert property (
    tick && pickup_q && 32'(MEAS_MAG) >= drop_lvl |=> pickup_q)
    else $error("pickup dropped above hysteresis level");
endmodule

// ### shared/psb_pkg.sv
package psb_pkg;
  localparam int PSB_CLK_HZ      = 20_000_000;
  localparam int PSB_TICK_US     = 5000;    // one program cycle, one step
  localparam int PSB_TICK_CYC    = PSB_CLK_HZ / 1_000_000 * PSB_TICK_US;
  localparam int PSB_DEF_DLY_US  = 40000;   // default definite delay
  localparam int PSB_BLK_LEAD_US = 5000;    // blocking lead the source owes
  localparam int PSB_HYST_PCT    = 97;      // drop-out ratio in percent
  localparam int PSB_PCT_FULL    = 100;
  localparam int PSB_TDIAL_DIV   = 100;     // k counted in hundredths
  localparam int PSB_RATIO_FRAC  = 3;       // ratio kept in eighths
  // register indices on the plain port
  localparam logic [3:0] PSB_A_CTRL  = 4'h0;
  localparam logic [3:0] PSB_A_DEF   = 4'h1;
  localparam logic [3:0] PSB_A_TDIAL = 4'h2;
  localparam logic [3:0] PSB_A_RELD  = 4'h3;
  localparam logic [3:0] PSB_A_PICK  = 4'h4;
  localparam logic [3:0] PSB_A_CUSTA = 4'h5;
  localparam logic [3:0] PSB_A_STAT  = 4'h6;
  localparam logic [3:0] PSB_A_EVT   = 4'h7;
  localparam logic [3:0] PSB_A_MASK  = 4'h8;
  localparam logic [3:0] PSB_A_RMAG  = 4'h9;
  localparam logic [3:0] PSB_A_RINFO = 4'hA;
  localparam logic [3:0] PSB_A_RTIME = 4'hB;
  // reset values
  localparam logic [23:0] PSB_DEF_RST =
    24'(PSB_DEF_DLY_US / PSB_TICK_US);
  localparam logic [11:0] PSB_TDIAL_RST = 12'h005;
  localparam logic [15:0] PSB_PICK_RST  = 16'h0100;
  localparam logic [15:0] PSB_CUSTA_RST = 16'h0040;
  // curve scales in ticks at k=1, ratio excess one eighth; neutral values
  localparam logic [15:0] PSB_IEC_SCALE [4] =
    '{16'h0040, 16'h1000, 16'h0400, 16'h2000};
  localparam logic [15:0] PSB_IEEE_SCALE [7] =
    '{16'h0100, 16'h0200, 16'h0300, 16'h0800,
      16'h0080, 16'h0180, 16'h0280};
  localparam logic [2:0] PSB_IEC_CUSTOM  = 3'h4;
  localparam logic [2:0] PSB_IEEE_CUSTOM = 3'h7;
  // event bits
  localparam int PSB_EV_BLOCK = 0;
  localparam int PSB_EV_START = 1;
  localparam int PSB_EV_TRIP  = 2;
  localparam int PSB_EV_W     = 3;

  typedef struct packed {
    logic [2:0] ieee_curve;   // ansi normal..ieee extreme, custom
    logic [2:0] iec_curve;    // normal, extreme, very, long, custom
    logic       series_ieee;  // curve family select
    logic       inv_mode;     // 0 fixed_delay_mode, 1 inverse_time_mode
  } psb_ctrl_t;

  typedef struct packed {
    logic start;
    logic blocked;
    logic trip;
  } psb_ind_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_TIMING, ST_RELEASE, ST_TRIPPED, ST_BLOCKED
  } psb_state_t;
endpackage

// ### core/psb_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for a pin level
module psb_sync
  import psb_pkg::*;
(
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic d,
  output logic      q
);
  logic meta_q;  // first stage, read only by the second

  // plain double flop, nothing taps the first stage
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ### core/psb_inv_delay.sv
`timescale 1ns/100ps
// inverse-time delay in ticks from ratio of magnitude to setting
module psb_inv_delay
  import psb_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire psb_ctrl_t   ctrl,
  input  wire logic [15:0] mag,
  input  wire logic [15:0] pick,
  input  wire logic [11:0] tdial,
  input  wire logic [15:0] cust_a,
  output logic      [23:0] ticks_q
);
  logic [19:0] ratio;   // measured over setting, in eighths
  logic [19:0] excess;  // ratio above one, never zero
  logic [15:0] scale;   // curve scale for the chosen curve
  logic [31:0] num;
  logic [31:0] den;
  logic [31:0] quo;

  // curve pick, custom entries use the user constant
  always_comb begin
    scale = cust_a;
    if (!ctrl.series_ieee) begin
      if (ctrl.iec_curve < PSB_IEC_CUSTOM)
        scale = PSB_IEC_SCALE[ctrl.iec_curve[1:0]];
    end else if (ctrl.ieee_curve < PSB_IEEE_CUSTOM) begin
      scale = PSB_IEEE_SCALE[ctrl.ieee_curve];
    end
  end

  // steeper ratio gives shorter delay; k scales linearly
  always_comb begin
    ratio  = (pick == 16'h0000) ? 20'h0_0000 :
             20'(({4'h0, mag} << PSB_RATIO_FRAC) / {4'h0, pick});
    excess = (ratio > 20'(1 << PSB_RATIO_FRAC)) ?
             20'(ratio - 20'(1 << PSB_RATIO_FRAC)) : 20'h0_0001;
    num    = 32'(scale) * 32'(tdial);
    den    = 32'(excess) * 32'(PSB_TDIAL_DIV);
    quo    = num / den;
  end

  // registered, saturated to the timer width
  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      ticks_q <= 24'h00_0000;
    else
      ticks_q <= (quo[31:24] != 8'h00) ? 24'hFF_FFFF : quo[23:0];
  end
endmodule

// ### tb/psb_far_model.sv
`timescale 1ns/100ps
// blocking matrix and fault source on the far side of the stage
module psb_far_model
  import psb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        blk_cmd,    // bench asks for blocking
  input  wire logic [15:0] mag_cmd,    // wanted measured_magnitude
  input  wire logic [3:0]  fault_cmd,  // wanted fault type code
  output logic             blk_out,    // blocking pin of the stage
  output logic      [15:0] mag_out,    // measured_magnitude to stage
  output logic      [3:0]  fault_out   // fault type to stage
);
  // quiet matrix at power-up
  initial begin
    blk_out = 1'b0;
    mag_out = 16'h0000;
    fault_out = 4'h0;
  end

  // matrix output is registered, one clock of latency; the bench
  // owes the lead of one program cycle before the delay runs out
  always @(posedge clk) begin
    blk_out <= blk_cmd;
    mag_out <= mag_cmd;
    fault_out <= fault_cmd;
  end
endmodule

// ### tb/psb_stage_bench.sv
`timescale 1ns/100ps
// self-checking bench for the protection stage
module psb_stage_bench
  import psb_pkg::*;
;
  localparam int TC = 10;           // short program cycle in clocks
  logic        clk       = 1'b0;    // 20 MHz
  logic        rst       = 1'b1;    // async reset
  logic [3:0]  reg_addr  = 4'h0;    // register index
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr    = 1'b0;    // write strobe
  logic        reg_rd    = 1'b0;    // read strobe
  logic [31:0] reg_rdata;           // read data
  logic        blk_cmd   = 1'b0;    // blocking request to matrix
  logic [15:0] mag_cmd   = 16'h0000;
  logic [3:0]  fault_cmd = 4'h0;
  logic        blk_pin;             // matrix outputs
  logic [15:0] mag;
  logic [3:0]  fault;
  logic        start;               // stage outputs
  logic        blocked;
  logic        trip;
  logic        hmi_evt;
  logic        irq;
  int          err_total   = 0;
  int          checks_done = 0;
  int          hmi_seen    = 0;     // display pulses counted
  logic [31:0] rv;                  // last read value

  always #25 clk = ~clk;

  psb_stage #(.TICK_CYC(TC)) i_psb_stage (
    .CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .BLOCK_IN(blk_pin), .MEAS_MAG(mag), .FAULT_TYPE(fault),
    .START(start), .BLOCKED(blocked), .TRIP(trip), .HMI_EVT(hmi_evt),
    .IRQ(irq));

  psb_far_model i_psb_far_model (
    .clk(clk), .blk_cmd(blk_cmd), .mag_cmd(mag_cmd),
    .fault_cmd(fault_cmd), .blk_out(blk_pin), .mag_out(mag),
    .fault_out(fault));

  // count display pulses; a pulse is one clock long
  always @(posedge clk) begin
    if (hmi_evt === 1'b1) hmi_seen++;
  end

  // value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // clock-span compare
  task automatic chk_span(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  function automatic logic pick(input int sel);
    return (sel == 0) ? start : (sel == 1) ? trip : blocked;
  endfunction

  // bounded wait for start(0), trip(1) or blocked(2)
  task automatic wait_lvl(input int sel, input logic lvl, input int lim,
                          output int cnt);
    cnt = 0;
    while (pick(sel) !== lvl && cnt < lim) begin
      @(posedge clk);
      #1 cnt++;
    end
  endtask

  // expected inverse delay in ticks, k = 1.00, setting at reset
  function automatic int inv(input logic [15:0] sc, input logic [15:0] m);
    int ex;
    ex = int'(m) * 8 / int'(PSB_PICK_RST) - 8;
    if (ex < 1) ex = 1;
    return int'(sc) * 100 / (PSB_TDIAL_DIV * ex);
  endfunction

  // drop pick-up and blocking, then all indications must fall
  task automatic settle();
    mag_cmd <= 16'h0000;
    blk_cmd <= 1'b0;
    repeat (4 * TC) @(posedge clk);
    #1 chk({29'h0, start, blocked, trip}, 32'h0000_0000);
  endtask

  // pick-up, then clocks from start to trip must equal the delay
  task automatic run_trip(input logic [15:0] m, input int ticks);
    int c;
    mag_cmd <= m;
    wait_lvl(0, 1'b1, 3 * TC, c);
    wait_lvl(1, 1'b1, (ticks + 2) * TC, c);
    chk_span(c, ticks * TC);
    settle();
  endtask

  task automatic t_reset_values();
    rd(PSB_A_CTRL, rv);
    chk(rv, 32'h0000_0000);
    rd(PSB_A_DEF, rv);
    chk(rv, 32'h0000_0008);
    rd(PSB_A_TDIAL, rv);
    chk(rv, 32'h0000_0005);
    rd(4'hC, rv);
    chk(rv, 32'h0000_0000);
    $display("test reset values done");
  endtask

  task automatic t_fixed();
    wr(PSB_A_DEF, 32'h0000_0002);
    run_trip(16'h0200, 2);
    run_trip(16'h0800, 2);
    wr(PSB_A_DEF, 32'h0000_0000);
    run_trip(16'h0200, 0);
    $display("test fixed delay done");
  endtask

  task automatic t_drop();
    int c;
    wr(PSB_A_DEF, 32'h0000_0004);
    mag_cmd <= 16'h0200;
    wait_lvl(0, 1'b1, 3 * TC, c);
    repeat (2 * TC) @(posedge clk);
    mag_cmd <= 16'h0000;
    wait_lvl(0, 1'b0, 3 * TC, c);
    chk(32'(start), 32'h0000_0000);
    repeat (6 * TC) @(posedge clk);
    #1 chk(32'(trip), 32'h0000_0000);
    $display("test early drop done");
  endtask

  // release timer holds the operate count while pick-up is away
  task automatic t_release();
    int c;
    rd(PSB_A_EVT, rv);
    wr(PSB_A_DEF, 32'h0000_0004);
    wr(PSB_A_RELD, 32'h0000_0002);
    mag_cmd <= 16'h0200;
    wait_lvl(0, 1'b1, 3 * TC, c);
    repeat (2 * TC) @(posedge clk);
    mag_cmd <= 16'h0000;
    wait_lvl(0, 1'b0, 3 * TC, c);
    mag_cmd <= 16'h0200;
    wait_lvl(0, 1'b1, 3 * TC, c);
    // two ticks were banked before the drop, two remain
    wait_lvl(1, 1'b1, 6 * TC, c);
    chk_span(c, 2 * TC);
    rd(PSB_A_STAT, rv);
    chk(rv, 32'h0000_000D);
    rd(PSB_A_EVT, rv);
    chk(rv, 32'h0000_0006);
    wr(PSB_A_RELD, 32'h0000_0000);
    settle();
    $display("test release timing done");
  endtask

  task automatic t_block_late();
    int c;
    int h0;
    rd(PSB_A_EVT, rv);
    wr(PSB_A_DEF, 32'h0000_0008);
    fault_cmd <= 4'h5;
    h0 = hmi_seen;
    mag_cmd <= 16'h0200;
    wait_lvl(0, 1'b1, 3 * TC, c);
    repeat (2 * TC) @(posedge clk);
    blk_cmd <= 1'b1;
    wait_lvl(0, 1'b0, 3 * TC, c);
    chk(32'(start), 32'h0000_0000);
    repeat (10 * TC) @(posedge clk);
    // pick-up still under blocking: the idle stage blocks once more
    #1 chk({29'h0, start, blocked, trip}, 32'h0000_0002);
    chk_span(hmi_seen - h0, 2);
    chk(32'(irq), 32'h0000_0000);
    wr(PSB_A_MASK, 32'h0000_0001);
    #1 chk(32'(irq), 32'h0000_0001);
    rd(PSB_A_RINFO, rv);
    chk(rv & 32'h0000_000F, 32'h0000_0005);
    rd(PSB_A_RMAG, rv);
    chk(rv, 32'h0000_0200);
    rd(PSB_A_EVT, rv);
    chk(rv & 32'h0000_0001, 32'h0000_0001);
    #1 chk(32'(irq), 32'h0000_0000);
    settle();
    $display("test late blocking done");
  endtask

  task automatic t_block_early();
    int c;
    blk_cmd <= 1'b1;
    repeat (2 * TC) @(posedge clk);
    mag_cmd <= 16'h0200;
    wait_lvl(2, 1'b1, 3 * TC, c);
    chk({30'h0, start, blocked}, 32'h0000_0001);
    repeat (10 * TC) @(posedge clk);
    #1 chk({30'h0, start, trip}, 32'h0000_0000);
    settle();
    $display("test early blocking done");
  endtask

  task automatic t_hyst();
    int c;
    wr(PSB_A_DEF, 32'h0000_0100);
    mag_cmd <= 16'h0100;
    wait_lvl(0, 1'b1, 3 * TC, c);
    chk(32'(start), 32'h0000_0001);
    mag_cmd <= 16'h00F9;
    repeat (3 * TC) @(posedge clk);
    #1 chk(32'(start), 32'h0000_0001);
    mag_cmd <= 16'h00F7;
    wait_lvl(0, 1'b0, 3 * TC, c);
    chk(32'(start), 32'h0000_0000);
    settle();
    $display("test hysteresis done");
  endtask

  // every curve of both families, custom ones use the reset constant
  task automatic t_inverse();
    logic [15:0] sc;
    wr(PSB_A_DEF, 32'h0000_0000);
    wr(PSB_A_TDIAL, 32'h0000_0064);
    for (int i = 0; i < 5; i++) begin
      sc = (i == 4) ? PSB_CUSTA_RST : PSB_IEC_SCALE[i];
      wr(PSB_A_CTRL, 32'h0000_0001 | 32'(i << 2));
      run_trip(16'h0300, inv(sc, 16'h0300));
    end
    wr(PSB_A_CTRL, 32'h0000_0001);
    run_trip(16'h0200, inv(PSB_IEC_SCALE[0], 16'h0200));
    wr(PSB_A_DEF, 32'h0000_0006);
    run_trip(16'h0300, 6);
    wr(PSB_A_DEF, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      sc = (i == 7) ? PSB_CUSTA_RST : PSB_IEEE_SCALE[i];
      wr(PSB_A_CTRL, 32'h0000_0003 | 32'(i << 5));
      run_trip(16'h0300, inv(sc, 16'h0300));
    end
    $display("test inverse time done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog, well beyond the some 13000 clocks the tests take
  initial begin
    #(60000 * 50);
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_fixed();
    t_drop();
    t_release();
    t_block_late();
    t_block_early();
    t_hyst();
    t_inverse();
    tally_and_finish();
  end
endmodule
